/* shared/cwb_pkg.sv */
// constants, record layout and state codes of the bus wake and boot buffer
// assumes a 100 MHz core clock and one 20-byte record per received message
package cwb_pkg;

    // -------------------------------------------------------------------
    // timing
    // -------------------------------------------------------------------
    localparam int CLK_HZ      = 100_000_000;
    localparam int LOSS_MS     = 30;
    localparam int LOSS_CYC    = LOSS_MS * (CLK_HZ / 1000);
    localparam int LOSS_W      = 22;
    localparam int BOOT_S      = 20;
    localparam int QS_IDLE_MS  = 1000;
    localparam int QS_IDLE_CYC = QS_IDLE_MS * (CLK_HZ / 1000);
    localparam int IDLE_W      = 28;

    // -------------------------------------------------------------------
    // buffer sizing
    // -------------------------------------------------------------------
    localparam int REC_BYTES  = 20;
    localparam int REC_W      = REC_BYTES * 8;
    localparam int BUF_BYTES  = 16 * 1024 * 1024;
    localparam int BUF_MSGS   = BUF_BYTES / REC_BYTES;
    localparam int FIFO_DEPTH = 8;
    localparam int NUM_CH     = 4;
    localparam int OCC_W      = 32;

    // -------------------------------------------------------------------
    // record fields
    // -------------------------------------------------------------------
    localparam int CH_LO   = 152;
    localparam int CH_HI   = 159;
    localparam int ID_LO   = 120;
    localparam int ID_HI   = 151;
    localparam int DLC_LO  = 112;
    localparam int DLC_HI  = 119;
    localparam int DATA_LO = 48;
    localparam int DATA_HI = 111;
    localparam int TS_LO   = 0;
    localparam int TS_HI   = 47;

    // -------------------------------------------------------------------
    // indicator blink timing
    // -------------------------------------------------------------------
    localparam int BLINK_W  = 27;
    localparam int FAST_BIT = 22;
    localparam int SLOT_LO  = 23;

    typedef enum logic [4:0] {
        ST_SLEEP   = 5'h01,
        ST_WAIT_LP = 5'h02,
        ST_WAIT_NL = 5'h04,
        ST_BOOT    = 5'h08,
        ST_RUN     = 5'h10
    } cwb_state_type;

endpackage : cwb_pkg

/* verilog/cwb_fifo.sv */
// first-in first-out record store with valid/ready on both sides
// assumes one clock; count gives honest full and empty
`timescale 1ns/1ps
module cwb_fifo #(
    parameter int W = 160,
    parameter int D = 8
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;

    logic [W-1:0]  mem [D];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0]   cnt_r;
    wire           push;
    wire           pop;

    assign in_ready  = (cnt_r != (AW+1)'(D));
    assign out_valid = (cnt_r != '0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem[rd_r];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_r] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(D - 1)) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(D - 1)) ? '0 : rd_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    count_range_a: assert property (@(posedge clk) disable iff (!nrst) // [RL8]
        cnt_r <= (AW+1)'(D))
        else $error("fifo count above depth");

endmodule : cwb_fifo

/* verilog/cwb_wake_buffer.sv */
// bus wake detection, boot-time message buffer and indicators of a can module
// assumes records arrive already framed, one per msg_valid, on the core clock
//
// Contract
// (RL1) enabled-channel traffic raises logger start request
// (RL2) optionally wake only on one message bit
// (RL3) low-power wake loses at most 30 ms
// (RL4) no-loss wake keeps receive path on
// (RL5) buffer while booting, forward after boot done
// (RL6) each message is one 20-byte record
// (RL7) one store shared by all channels
// (RL8) fifo order, drop new records when full
// (RL9) two-channel build splits store over two nodes
// (RL10) bus wake drives external power switch output
// (RL11) link and per-channel activity indicators
// (RL12) per-channel wake indicator blink codes
// (RL13) quick-start: activity starts and stops logger
// (RL14) forward in arrival order, live included
// (RL15) sticky overflow flag, cleared by logger
`timescale 1ns/1ps
module cwb_wake_buffer #(
    parameter int NUM_CH     = cwb_pkg::NUM_CH,
    parameter int BUF_DEPTH  = cwb_pkg::FIFO_DEPTH,
    parameter int LOSS_CYC   = cwb_pkg::LOSS_CYC,
    parameter int IDLE_CYC   = cwb_pkg::QS_IDLE_CYC,
    parameter bit HAS_SWITCH = 1'b1
) (
    input  wire logic                     clk,
    input  wire logic                     nrst,
    input  wire logic [NUM_CH-1:0]        can_rx,
    input  wire logic                     wake_on_bus_activity,
    input  wire logic                     wake_no_loss_mode,
    input  wire logic [NUM_CH-1:0]        chan_en,
    input  wire logic                     qual_en,
    input  wire logic [31:0]              qual_id,
    input  wire logic [5:0]               qual_bit,
    input  wire logic                     qual_value,
    input  wire logic                     quick_start_en,
    input  wire logic                     logger_on,
    input  wire logic                     boot_done,
    input  wire logic                     msg_valid,
    input  wire logic [cwb_pkg::REC_W-1:0] msg_rec,
    output logic                          msg_ready,
    output logic                          out_valid,
    input  wire logic                     out_ready,
    output logic [cwb_pkg::REC_W-1:0]     out_rec,
    input  wire logic                     ovf_clr,
    output logic                          ovf_flag,
    output logic                          start_req,
    output logic                          stop_req,
    output logic                          ext_power_on,
    output logic                          rx_path_en,
    output logic [NUM_CH-1:0]             share_full,
    output logic                          link_led,
    output logic [NUM_CH-1:0]             rxtx_led,
    output logic [NUM_CH-1:0]             wake_led
);
    localparam int LW = cwb_pkg::LOSS_W;
    localparam int IW = cwb_pkg::IDLE_W;
    localparam int SHARE = BUF_DEPTH / NUM_CH;

    // -------------------------------------------------------------------
    // pin synchronisers and dominant-level filter
    // -------------------------------------------------------------------
    logic [NUM_CH-1:0] s1_r;
    logic [NUM_CH-1:0] s2_r;
    logic [NUM_CH-1:0] s3_r;
    logic [NUM_CH-1:0] filt_r;
    wire  [NUM_CH-1:0] filt_nxt;
    wire  [NUM_CH-1:0] act;
    wire               act_any;

    assign filt_nxt = (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));
    assign act      = ~filt_r & chan_en;
    assign act_any  = |act;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_r   <= '1;
            s2_r   <= '1;
            s3_r   <= '1;
            filt_r <= '1;
        end else begin
            s1_r   <= can_rx;
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            filt_r <= filt_nxt;
        end
    end

    // -------------------------------------------------------------------
    // record fields and wake qualification
    // -------------------------------------------------------------------
    cwb_pkg::cwb_state_type st_r;
    cwb_pkg::cwb_state_type st_nxt;
    logic              armed_r;
    logic [LW-1:0]     loss_r;
    logic [IW-1:0]     idle_r;
    logic [NUM_CH-1:0] woke_r;
    logic              stop_r;
    wire  [7:0]        msg_ch;
    wire  [31:0]       msg_id;
    wire  [63:0]       msg_data;
    wire               ch_ok;
    wire               qual_hit;
    wire               wake_hit;
    wire               waiting;
    wire               rx_on;
    wire               accept;
    wire               push;
    wire               drop;
    wire               fifo_in_ready;
    wire               fifo_out_valid;
    wire               drain;
    wire               loss_load;
    wire               idle_done;

    // each record is one fixed 20-byte word [RL6]
    assign msg_ch   = msg_rec[cwb_pkg::CH_HI:cwb_pkg::CH_LO];
    assign msg_id   = msg_rec[cwb_pkg::ID_HI:cwb_pkg::ID_LO];
    assign msg_data = msg_rec[cwb_pkg::DATA_HI:cwb_pkg::DATA_LO];
    assign ch_ok    = (msg_ch < 8'(NUM_CH)) && chan_en[msg_ch[1:0]];

    assign waiting  = (st_r == cwb_pkg::ST_WAIT_LP) || (st_r == cwb_pkg::ST_WAIT_NL);
    assign rx_on    = (st_r == cwb_pkg::ST_WAIT_NL) || (st_r == cwb_pkg::ST_BOOT)
                    || (st_r == cwb_pkg::ST_RUN) || armed_r;                 // [RL4]
    assign qual_hit = msg_valid && rx_on && ch_ok && (msg_id == qual_id)
                    && (msg_data[qual_bit] == qual_value);                   // [RL2]
    assign wake_hit = qual_en ? qual_hit : act_any;                         // [RL1]
    assign loss_load = (st_r == cwb_pkg::ST_WAIT_LP) && act_any && !armed_r; // [RL3]
    assign idle_done = (idle_r == IW'(IDLE_CYC));

    // -------------------------------------------------------------------
    // wake state machine
    // -------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            cwb_pkg::ST_SLEEP: begin
                if (logger_on && !stop_r) begin
                    st_nxt = cwb_pkg::ST_BOOT;
                end else if (!logger_on && wake_on_bus_activity) begin
                    st_nxt = wake_no_loss_mode ? cwb_pkg::ST_WAIT_NL : cwb_pkg::ST_WAIT_LP;
                end
            end
            cwb_pkg::ST_WAIT_LP, cwb_pkg::ST_WAIT_NL: begin
                if (logger_on || wake_hit) begin
                    st_nxt = cwb_pkg::ST_BOOT;
                end else if (!wake_on_bus_activity) begin
                    st_nxt = cwb_pkg::ST_SLEEP;
                end
            end
            cwb_pkg::ST_BOOT: begin
                if (boot_done) begin
                    st_nxt = cwb_pkg::ST_RUN;                                // [RL5]
                end
            end
            cwb_pkg::ST_RUN: begin
                if (!logger_on) begin
                    st_nxt = cwb_pkg::ST_SLEEP;
                end
            end
            default: st_nxt = cwb_pkg::ST_SLEEP;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r    <= cwb_pkg::ST_SLEEP;
            armed_r <= 1'b0;
            woke_r  <= '0;
        end else begin
            st_r    <= st_nxt;
            armed_r <= waiting && (armed_r || loss_load) && (st_nxt == st_r);
            if (waiting && wake_hit && !logger_on) begin
                woke_r <= qual_en ? (NUM_CH'(1) << msg_ch[1:0]) : act;
            end else if (st_r == cwb_pkg::ST_SLEEP) begin
                woke_r <= '0;
            end
        end
    end

    // loss window after a low-power wake, never longer than LOSS_CYC
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            loss_r <= '0;
        end else if (loss_load) begin
            loss_r <= LW'(LOSS_CYC);                                         // [RL3]
        end else if (st_r == cwb_pkg::ST_SLEEP) begin
            loss_r <= '0;                                                    // [RL4]
        end else if (loss_r != '0) begin
            loss_r <= loss_r - 1'b1;
        end
    end

    // quick-start: bus silence in run ends a logging session that a bus wake started
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            idle_r <= '0;
            stop_r <= 1'b0;
        end else begin
            if (st_r != cwb_pkg::ST_RUN || act_any) begin
                idle_r <= '0;
            end else if (!idle_done) begin
                idle_r <= idle_r + 1'b1;
            end
            if (!logger_on) begin
                stop_r <= 1'b0;
            end else if (quick_start_en && idle_done && (woke_r != '0)) begin
                stop_r <= 1'b1;                                              // [RL13]
            end
        end
    end

    // -------------------------------------------------------------------
    // buffer path
    // -------------------------------------------------------------------
    assign accept    = msg_valid && rx_on && ch_ok && (loss_r == '0);        // [RL3]
    assign push      = accept && fifo_in_ready;
    assign drop      = accept && !fifo_in_ready;                             // [RL8]
    assign drain     = (st_r == cwb_pkg::ST_RUN);
    assign out_valid = fifo_out_valid && drain;                              // [RL5]
    assign msg_ready = fifo_in_ready;

    // one store for every channel; buffered and live records share it [RL7] [RL14]
    cwb_fifo #(
        .W (cwb_pkg::REC_W),
        .D (BUF_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (accept),
        .in_ready  (fifo_in_ready),
        .in_data   (msg_rec),
        .out_valid (fifo_out_valid),
        .out_ready (out_ready && drain),
        .out_data  (out_rec)
    );

    // per-node share of the store, half of it each for a two-channel build [RL9]
    genvar gc;
    generate
        for (gc = 0; gc < NUM_CH; gc++) begin : g_share
            logic [cwb_pkg::OCC_W-1:0] occ_r;
            wire inc = push && (msg_ch == 8'(gc));
            wire dec = out_valid && out_ready
                     && (out_rec[cwb_pkg::CH_HI:cwb_pkg::CH_LO] == 8'(gc));
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    occ_r <= '0;
                end else begin
                    occ_r <= occ_r + cwb_pkg::OCC_W'(inc) - cwb_pkg::OCC_W'(dec);
                end
            end
            assign share_full[gc] = (occ_r >= cwb_pkg::OCC_W'(SHARE));     // [RL9]
        end
    endgenerate

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ovf_flag <= 1'b0;
        end else if (drop) begin
            ovf_flag <= 1'b1;                                                // [RL15]
        end else if (ovf_clr) begin
            ovf_flag <= 1'b0;                                                // [RL15]
        end
    end

    // -------------------------------------------------------------------
    // logger control outputs
    // -------------------------------------------------------------------
    assign start_req    = (st_r == cwb_pkg::ST_BOOT) && (woke_r != '0);      // [RL1]
    assign stop_req     = stop_r;                                            // [RL13]
    assign ext_power_on = HAS_SWITCH && (woke_r != '0)
                        && ((st_r == cwb_pkg::ST_BOOT) || (st_r == cwb_pkg::ST_RUN)); // [RL10]
    assign rx_path_en   = rx_on;

    // -------------------------------------------------------------------
    // indicators
    // -------------------------------------------------------------------
    logic [cwb_pkg::BLINK_W-1:0] blink_r;
    wire  [3:0]                  slot;
    wire                         fast;
    wire                         dbl;
    logic [NUM_CH-1:0]           wled_nxt;

    assign slot = blink_r[cwb_pkg::SLOT_LO+3:cwb_pkg::SLOT_LO];
    assign fast = blink_r[cwb_pkg::FAST_BIT];
    assign dbl  = (slot == 4'h0) || (slot == 4'h2);

    always_comb begin
        wled_nxt = '0;
        if (wake_on_bus_activity || (st_r == cwb_pkg::ST_RUN)) begin
            unique case (st_r)
                cwb_pkg::ST_SLEEP:   wled_nxt = '0;
                cwb_pkg::ST_WAIT_LP: wled_nxt = {NUM_CH{dbl}};
                cwb_pkg::ST_WAIT_NL: wled_nxt = '1;
                cwb_pkg::ST_BOOT:    wled_nxt = woke_r & {NUM_CH{fast}};
                cwb_pkg::ST_RUN:     wled_nxt = '1;
                default:             wled_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            blink_r  <= '0;
            wake_led <= '0;
            rxtx_led <= '0;
            link_led <= 1'b0;
        end else begin
            blink_r  <= blink_r + 1'b1;
            wake_led <= wled_nxt;                                            // [RL12]
            rxtx_led <= act;                                                 // [RL11]
            link_led <= out_valid && out_ready;                              // [RL11]
        end
    end

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    wake_request_a: assert property (@(posedge clk) disable iff (!nrst) // [RL1]
        (waiting && !qual_en && act_any && !logger_on) |=> start_req)
        else $error("bus activity did not request logger start");

    qual_wait_a: assert property (@(posedge clk) disable iff (!nrst) // [RL2]
        ((st_r == cwb_pkg::ST_WAIT_NL) && qual_en && !qual_hit && !logger_on
         && wake_on_bus_activity) |=> (st_r == cwb_pkg::ST_WAIT_NL))
        else $error("woke without qualifying message bit");

    loss_window_a: assert property (@(posedge clk) disable iff (!nrst) // [RL3]
        (loss_r != '0) |=> (loss_r == $past(loss_r) - 1'b1) || $past(loss_load)
        || ((loss_r == '0) && ($past(st_r) == cwb_pkg::ST_SLEEP)))
        else $error("loss window not counting down");

    no_loss_rx_a: assert property (@(posedge clk) disable iff (!nrst) // [RL4]
        (st_r == cwb_pkg::ST_WAIT_NL) |-> rx_path_en && (loss_r == '0))
        else $error("receive path off in no-loss wait");

    boot_hold_a: assert property (@(posedge clk) disable iff (!nrst) // [RL5]
        (st_r == cwb_pkg::ST_BOOT && !boot_done) |=> !out_valid)
        else $error("forwarding before boot done");

    full_drop_a: assert property (@(posedge clk) disable iff (!nrst) // [RL8]
        drop |=> ovf_flag && !$past(fifo_in_ready))
        else $error("drop on full not flagged");

    switch_out_a: assert property (@(posedge clk) disable iff (!nrst) // [RL10]
        (waiting && wake_hit && !logger_on) |=> (ext_power_on == HAS_SWITCH))
        else $error("switch output off during bus wake boot");

    nl_led_a: assert property (@(posedge clk) disable iff (!nrst) // [RL12]
        ((st_r == cwb_pkg::ST_WAIT_NL) && wake_on_bus_activity) |=> (wake_led == '1))
        else $error("no-loss wait indicator not steady");

    ovf_clear_a: assert property (@(posedge clk) disable iff (!nrst) // [RL15]
        (ovf_clr && !drop) |=> !ovf_flag)
        else $error("overflow flag not cleared");

endmodule : cwb_wake_buffer

/* verif/cwb_logger_model.sv */
// logger base unit model: boots on a start request, then takes records
// assumes the block's output side runs on the same clock
`timescale 1ns/1ps
module cwb_logger_model #(
    parameter int BOOT_CYC = 60
) (
    input  wire logic                      clk,
    input  wire logic                      nrst,
    input  wire logic                      start_req,
    input  wire logic                      out_valid,
    input  wire logic [cwb_pkg::REC_W-1:0] out_rec,
    input  wire logic                      stall,
    input  wire logic                      shutdown,
    output logic                           logger_on,
    output logic                           boot_done,
    output logic                           out_ready
);
    logic [cwb_pkg::REC_W-1:0] got [$];
    int                        cnt;

    // ----------------------------------------------------------------
    // boot sequence and record sink
    // ----------------------------------------------------------------
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            logger_on <= 1'b0;
            boot_done <= 1'b0;
            out_ready <= 1'b0;
            cnt <= 0;
        end else if (shutdown) begin
            logger_on <= 1'b0;
            boot_done <= 1'b0;
            out_ready <= 1'b0;
            cnt <= 0;
        end else begin
            if (start_req === 1'b1)
                logger_on <= 1'b1;
            if (logger_on && cnt < BOOT_CYC)
                cnt <= cnt + 1;
            boot_done <= logger_on && cnt >= BOOT_CYC;
            out_ready <= boot_done && !stall;
            if (out_valid === 1'b1 && out_ready)
                got.push_back(out_rec);
        end
    end
endmodule : cwb_logger_model

/* verif/testbench.sv */
// self-checking bench of the bus wake and boot buffer block
// assumes the logger model on the output side, scaled counts
`timescale 1ns/1ps
`define CHK(g, e, m) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %0t %s", $time, m); end end
`define WAITC(c, n) begin for (int k = 0; k < (n) && (c) !== 1'b1; k++) @(posedge clk); \
    if ((c) !== 1'b1) begin n_mismatch++; tally_and_finish(); end end
module testbench;
    logic         clk, nrst, wake_on, no_loss, qual_en, qual_value, quick_en;
    logic         logger_on, boot_done, msg_valid, msg_ready, out_valid, out_ready;
    logic         ovf_clr, ovf_flag, start_req, stop_req, ext_pwr, rx_en, link_led;
    logic         stall, shutdown, seen_link;
    logic [3:0]   can_rx, chan_en, share_full, rxtx_led, wake_led, seen_rxtx;
    logic [31:0]  qual_id;
    logic [5:0]   qual_bit;
    logic [159:0] msg_rec, out_rec, r;
    logic [159:0] exp [$];
    int           n_mismatch, n_compared;

    cwb_wake_buffer #(.NUM_CH(4), .BUF_DEPTH(8), .LOSS_CYC(20), .IDLE_CYC(50)) cwb_wake_buffer_i (
        .clk(clk), .nrst(nrst), .can_rx(can_rx), .wake_on_bus_activity(wake_on),
        .wake_no_loss_mode(no_loss), .chan_en(chan_en), .qual_en(qual_en), .qual_id(qual_id),
        .qual_bit(qual_bit), .qual_value(qual_value), .quick_start_en(quick_en),
        .logger_on(logger_on), .boot_done(boot_done), .msg_valid(msg_valid), .msg_rec(msg_rec),
        .msg_ready(msg_ready), .out_valid(out_valid), .out_ready(out_ready), .out_rec(out_rec),
        .ovf_clr(ovf_clr), .ovf_flag(ovf_flag), .start_req(start_req), .stop_req(stop_req),
        .ext_power_on(ext_pwr), .rx_path_en(rx_en), .share_full(share_full),
        .link_led(link_led), .rxtx_led(rxtx_led), .wake_led(wake_led));
    cwb_logger_model cwb_logger_model_i (
        .clk(clk), .nrst(nrst), .start_req(start_req), .out_valid(out_valid),
        .out_rec(out_rec), .stall(stall), .shutdown(shutdown), .logger_on(logger_on),
        .boot_done(boot_done), .out_ready(out_ready));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [159:0] mk(input int ch, input logic [31:0] id,
                                        input logic [63:0] d, input int seq);
        return {ch[7:0], id, 8'h08, d, 16'h0000, seq[31:0]};
    endfunction : mk

    task send(input logic [159:0] rec);
        msg_valid <= 1'b1;
        msg_rec <= rec;
        @(posedge clk);
        msg_valid <= 1'b0;
        @(posedge clk);
    endtask : send

    task tally_and_finish;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish

    always @(posedge clk) begin
        if (nrst && link_led === 1'b1)
            seen_link <= 1'b1;
        if (nrst)
            seen_rxtx <= seen_rxtx | rxtx_led;
    end

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task s_disabled;
        `CHK(msg_ready, 1'b1, "ready after reset")
        `CHK(ext_pwr, 1'b0, "switch on after reset")
        can_rx <= 4'he;
        repeat (10) @(posedge clk);
        `CHK(start_req, 1'b0, "woke while disabled")
        `CHK(wake_led, 4'h0, "wake led lit while disabled")
        can_rx <= 4'hf;
        // let the pin filter see the bus idle before wake is enabled
        repeat (6) @(posedge clk);
    endtask : s_disabled

    task s_no_loss;
        wake_on <= 1'b1;
        no_loss <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK(rx_en, 1'b1, "rx off in no-loss wait")
        `CHK(wake_led, 4'hf, "wake led not steady")
        can_rx <= 4'hd;
        `WAITC(start_req, 12)
        `CHK(ext_pwr, 1'b1, "switch not on")
        can_rx <= 4'hf;
        for (int i = 0; i < 10; i++) begin
            msg_valid <= 1'b1;
            msg_rec <= mk(i % 4, 32'h10, 64'h0, i);
            if (i < 8)
                exp.push_back(mk(i % 4, 32'h10, 64'h0, i));
            @(posedge clk);
        end
        msg_valid <= 1'b0;
        @(posedge clk);
        `CHK(msg_ready, 1'b0, "ready while full")
        `CHK(ovf_flag, 1'b1, "overflow not flagged")
        `CHK(share_full, 4'hf, "shares not full")
        `CHK(out_valid, 1'b0, "output during boot")
        `WAITC(out_valid, 200)
        repeat (5) @(posedge clk);
        `CHK(out_rec, exp[0], "head record wrong")
        stall <= 1'b0;
        ovf_clr <= 1'b1;
        @(posedge clk);
        ovf_clr <= 1'b0;
        @(posedge clk);
        `CHK(ovf_flag, 1'b0, "overflow not cleared")
        exp.push_back(mk(3, 32'h11, 64'h5, 9));
        send(exp[8]);
        `WAITC((cwb_logger_model_i.got.size() == 9), 100)
        for (int i = 0; i < 9; i++)
            `CHK(cwb_logger_model_i.got[i], exp[i], "forward order")
        `CHK(seen_link, 1'b1, "link led never lit")
        `CHK(seen_rxtx[1], 1'b1, "rx led never lit")
    endtask : s_no_loss

    task s_quick;
        quick_en <= 1'b1;
        `WAITC(stop_req, 120)
        no_loss <= 1'b0;
        shutdown <= 1'b1;
        quick_en <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK(ext_pwr, 1'b0, "switch on after stop")
    endtask : s_quick

    task s_low_power;
        cwb_logger_model_i.got.delete();
        shutdown <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(rx_en, 1'b0, "rx on in low-power wait")
        can_rx <= 4'he;
        `WAITC(start_req, 20)
        can_rx <= 4'hf;
        send(mk(0, 32'h21, 64'h6, 0));
        no_loss <= 1'b1;
        repeat (25) @(posedge clk);
        r = mk(0, 32'h22, 64'h7, 1);
        send(r);
        `WAITC((cwb_logger_model_i.got.size() == 1), 200)
        `CHK(cwb_logger_model_i.got[0], r, "record lost after window")
    endtask : s_low_power

    task s_qualify;
        qual_en <= 1'b1;
        shutdown <= 1'b1;
        repeat (4) @(posedge clk);
        shutdown <= 1'b0;
        can_rx <= 4'he;
        repeat (10) @(posedge clk);
        `CHK(start_req, 1'b0, "woke on plain traffic")
        can_rx <= 4'hf;
        send(mk(0, 32'h123, 64'h0, 2));
        repeat (5) @(posedge clk);
        `CHK(start_req, 1'b0, "woke on wrong bit value")
        send(mk(0, 32'h123, 64'h20, 3));
        `WAITC(start_req, 10)
    endtask : s_qualify

    // ------------------------------------------------------------------
    // clock, reset, main sequence
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        {nrst, wake_on, no_loss, qual_en, quick_en, msg_valid, ovf_clr, shutdown} = '0;
        {seen_link, seen_rxtx, msg_rec, r} = '0;
        can_rx = 4'hf;
        chan_en = 4'hf;
        qual_id = 32'h123;
        qual_bit = 6'h05;
        qual_value = 1'b1;
        stall = 1'b1;
        n_mismatch = 0;
        n_compared = 0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        s_disabled();
        s_no_loss();
        s_quick();
        s_low_power();
        s_qualify();
        tally_and_finish();
    end
endmodule : testbench
